/* hdl/io_function_select.sv */
// per-line function selection for the configurable digital i/o lines
// Functional notes
// - free-use input: no action, status only
// - code 2: fault reset, local mode only
// - code 3: power stage enable, local only
// - code 4: halt input
// - code 9: jog clockwise request
// - code 10: jog counterclockwise request
// - code 11: jog fast/slow select
// - code 20: reference switch for homing
// - code 21 positive limit, line one only
// - negative limit, line two only
// - code 101 driven from direct set bit
// - direct set writes only reach free outputs
// - direct set bit n drives output n
// - code 102 outputs no-fault indication
// - code 103 outputs operation-enabled indication
// - 16-bit read/write selector per line
// - common functions allowed on every line
// - status bit n shows line n level
module io_function_select
  import io_select_pkg::*;
#(
  parameter int unsigned LINES = NUM_LINES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // parameter access port
  input wire logic par_sel,
  input wire logic par_we,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata,
  output logic par_ack,
  output logic par_err,
  // configurable lines
  input wire logic [LINES-1:0] line_in,
  output logic [LINES-1:0] line_out,
  output logic [LINES-1:0] line_oe,
  // drive state
  input wire logic local_mode,
  input wire logic drive_fault,
  input wire logic op_enabled,
  // functions towards the drive
  output logic fault_reset_req,
  output logic enable_req,
  output logic halt_req,
  output logic jog_pos_req,
  output logic jog_neg_req,
  output logic jog_fast,
  output logic ref_switch,
  output logic positive_limit_switch,
  output logic negative_limit_switch
);

  // the address map and every register below are laid out for four lines
  if (LINES != NUM_LINES) begin : g_bad_lines
    $error("io_function_select serves exactly four lines");
  end
  // direct set and status carry one parameter bit per line
  if (LINES > PAR_W) begin : g_too_wide
    $error("io_function_select needs one parameter bit per line");
  end
  // both limit switch lines must exist
  if (POS_LIMIT_LINE >= LINES || NEG_LIMIT_LINE >= LINES) begin : g_bad_limits
    $error("io_function_select has no line for a limit switch");
  end
  // no line may be driven straight out of reset
  if (FUNCTION_SELECT_RESET >= FN_OUT_FREE) begin : g_bad_reset
    $error("io_function_select must come up with every line an input");
  end

  // selector group
  logic [15:0] func_sel [LINES];
  logic [15:0] next_func_sel [LINES];
  // direct output-set group
  logic [LINES-1:0] direct_set;
  logic [LINES-1:0] next_direct_set;
  // parameter answer group
  logic [15:0] next_par_rdata;
  logic next_par_ack;
  logic next_par_err;
  // address decode of the current access
  logic [15:0] sel_addr [LINES];
  logic par_write;
  logic dset_write;
  logic [LINES-1:0] addr_is_sel;
  logic addr_is_dset;
  logic addr_is_status;
  logic addr_known;
  logic [15:0] sel_read;
  logic [LINES-1:0] sel_write;
  logic [LINES-1:0] code_ok;
  logic code_refused;
  // per-line decode
  logic [LINES-1:0] line_level;
  logic [LINES-1:0] hit_reset;
  logic [LINES-1:0] hit_enable;
  logic [LINES-1:0] hit_halt;
  logic [LINES-1:0] hit_jog_pos;
  logic [LINES-1:0] hit_jog_neg;
  logic [LINES-1:0] hit_fast;
  logic [LINES-1:0] hit_ref;
  logic [LINES-1:0] hit_pos_lim;
  logic [LINES-1:0] hit_neg_lim;
  logic [LINES-1:0] is_free_out;
  // line driver group
  logic [LINES-1:0] next_line_out;
  logic [LINES-1:0] next_line_oe;
  // function output group
  logic next_fault_reset_req;
  logic next_enable_req;
  logic next_halt_req;
  logic next_jog_pos_req;
  logic next_jog_neg_req;
  logic next_jog_fast;
  logic next_ref_switch;
  logic next_pos_lim;
  logic next_neg_lim;

  assign sel_addr[0] = ADDR_LINE1_FUNCTION_SELECT;
  assign sel_addr[1] = ADDR_LINE2_FUNCTION_SELECT;
  assign sel_addr[2] = ADDR_LINE3_FUNCTION_SELECT;
  assign sel_addr[3] = ADDR_LINE4_FUNCTION_SELECT;
  assign par_write = par_sel && par_we;
  assign dset_write = par_write && addr_is_dset;

  // per-line decode of the selected function
  for (genvar i = 0; i < LINES; i++) begin : g_line
    // input functions; free-use input (code 1) decodes to nothing here
    always_comb begin
      hit_reset[i] = (func_sel[i] == FN_IN_FAULT_RESET) && line_in[i];
      hit_enable[i] = (func_sel[i] == FN_IN_ENABLE) && line_in[i];
      hit_halt[i] = (func_sel[i] == FN_IN_HALT) && line_in[i];
      hit_jog_pos[i] = (func_sel[i] == FN_IN_JOG_POS) && line_in[i];
      hit_jog_neg[i] = (func_sel[i] == FN_IN_JOG_NEG) && line_in[i];
      hit_fast[i] = (func_sel[i] == FN_IN_JOG_FAST) && line_in[i];
      hit_ref[i] = (func_sel[i] == FN_IN_REF_SWITCH) && line_in[i];
      hit_pos_lim[i] = (func_sel[i] == FN_IN_POS_LIMIT) && line_in[i];
      hit_neg_lim[i] = (func_sel[i] == FN_IN_NEG_LIMIT) && line_in[i];
    end

    // output functions
    always_comb begin
      is_free_out[i] = (func_sel[i] == FN_OUT_FREE);
      next_line_oe[i] = (func_sel[i] == FN_OUT_FREE)
                      || (func_sel[i] == FN_OUT_NO_FAULT)
                      || (func_sel[i] == FN_OUT_ACTIVE);
      case (func_sel[i])
        FN_OUT_FREE: next_line_out[i] = direct_set[i];
        FN_OUT_NO_FAULT: next_line_out[i] = ~drive_fault;
        FN_OUT_ACTIVE: next_line_out[i] = op_enabled;
        default: next_line_out[i] = 1'b0;
      endcase
    end

    // a driven line reports what it drives, an input reports the pin
    always_comb begin
      line_level[i] = line_oe[i] ? line_out[i] : line_in[i];
    end
  end

  // several lines may carry one function; any of them raises it
  always_comb begin
    // fault reset and enable only act under local control
    next_fault_reset_req = local_mode && (|hit_reset);
    next_enable_req = local_mode && (|hit_enable);
    next_halt_req = |hit_halt;
    next_jog_pos_req = |hit_jog_pos;
    next_jog_neg_req = |hit_jog_neg;
    next_jog_fast = |hit_fast;
    next_ref_switch = |hit_ref;
    next_pos_lim = |hit_pos_lim;
    next_neg_lim = |hit_neg_lim;
  end

  // address decode, shared by the groups behind the parameter port
  always_comb begin
    addr_is_dset = (par_addr == ADDR_DIRECT_OUTPUT_SET);
    addr_is_status = (par_addr == ADDR_IO_STATUS_READOUT);
    addr_is_sel = '0;
    code_ok = '0;
    sel_read = 16'h0000;
    for (int unsigned i = 0; i < LINES; i++) begin
      addr_is_sel[i] = (par_addr == sel_addr[i]);
      case (par_wdata)
        FN_IN_FREE, FN_IN_FAULT_RESET, FN_IN_ENABLE, FN_IN_HALT, FN_IN_JOG_POS,
        FN_IN_JOG_NEG, FN_IN_JOG_FAST, FN_IN_REF_SWITCH, FN_OUT_FREE,
        FN_OUT_NO_FAULT, FN_OUT_ACTIVE: code_ok[i] = 1'b1;
        // limit switch codes pass on their own line only
        FN_IN_POS_LIMIT: code_ok[i] = (i == POS_LIMIT_LINE);
        FN_IN_NEG_LIMIT: code_ok[i] = (i == NEG_LIMIT_LINE);
        default: code_ok[i] = 1'b0;
      endcase
      if (addr_is_sel[i]) begin
        sel_read = func_sel[i];
      end
    end
    addr_known = addr_is_dset || addr_is_status || (|addr_is_sel);
    sel_write = par_write ? (addr_is_sel & code_ok) : '0;
    code_refused = par_write && (|(addr_is_sel & ~code_ok));
  end

  // selector group: a refused code leaves the old selection in place
  always_comb begin
    next_func_sel = func_sel;
    for (int unsigned i = 0; i < LINES; i++) begin
      if (sel_write[i]) begin
        next_func_sel[i] = par_wdata;
      end
    end
  end

  // selectors come up with no function: every line an undriven input
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < LINES; i++) begin
        func_sel[i] <= FUNCTION_SELECT_RESET;
      end
    end else begin
      func_sel <= next_func_sel;
    end
  end

  // direct output-set group
  always_comb begin
    next_direct_set = direct_set;
    if (dset_write) begin
      // bits of lines not set up as free outputs keep their value
      next_direct_set = (direct_set & ~is_free_out)
                      | (par_wdata[LINES-1:0] & is_free_out);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      direct_set <= DIRECT_OUTPUT_SET_RESET[LINES-1:0];
    end else begin
      direct_set <= next_direct_set;
    end
  end

  // parameter answer: one answer per selected cycle, one edge later
  always_comb begin
    next_par_rdata = par_rdata;
    next_par_ack = 1'b0;
    next_par_err = 1'b0;
    if (par_sel) begin
      next_par_ack = 1'b1;
      next_par_rdata = 16'h0000;
      if (addr_is_dset) begin
        next_par_rdata[LINES-1:0] = direct_set;
      end else if (addr_is_status) begin
        next_par_rdata[LINES-1:0] = line_level;
        // read-only: a write is refused
        next_par_err = par_we;
      end else begin
        // an unmapped address reads zero and is refused
        next_par_rdata = sel_read;
        next_par_err = !addr_known || code_refused;
      end
    end
  end

  // read data holds between accesses so a slow master can still take it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      par_rdata <= 16'h0000;
      par_ack <= 1'b0;
      par_err <= 1'b0;
    end else begin
      par_rdata <= next_par_rdata;
      par_ack <= next_par_ack;
      par_err <= next_par_err;
    end
  end

  // line driver group
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      line_out <= '0;
      line_oe <= '0;
    end else begin
      line_out <= next_line_out;
      line_oe <= next_line_oe;
    end
  end

  // function outputs are registered levels, one edge behind their lines
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fault_reset_req <= 1'b0;
      enable_req <= 1'b0;
      halt_req <= 1'b0;
      jog_pos_req <= 1'b0;
      jog_neg_req <= 1'b0;
      jog_fast <= 1'b0;
      ref_switch <= 1'b0;
      positive_limit_switch <= 1'b0;
      negative_limit_switch <= 1'b0;
    end else begin
      fault_reset_req <= next_fault_reset_req;
      enable_req <= next_enable_req;
      halt_req <= next_halt_req;
      jog_pos_req <= next_jog_pos_req;
      jog_neg_req <= next_jog_neg_req;
      jog_fast <= next_jog_fast;
      ref_switch <= next_ref_switch;
      positive_limit_switch <= next_pos_lim;
      negative_limit_switch <= next_neg_lim;
    end
  end

endmodule // io_function_select

/* hdl/io_select_pkg.sv */
// constants, function codes and parameter addresses of the configurable i/o selector
package io_select_pkg;
  localparam int unsigned NUM_LINES = 4;
  localparam int unsigned PAR_W = 16;
  // parameter addresses, one 16-bit parameter each
  localparam logic [15:0] ADDR_LINE1_FUNCTION_SELECT = 16'h0722;
  localparam logic [15:0] ADDR_LINE2_FUNCTION_SELECT = 16'h0724;
  localparam logic [15:0] ADDR_LINE3_FUNCTION_SELECT = 16'h0726;
  localparam logic [15:0] ADDR_LINE4_FUNCTION_SELECT = 16'h0728;
  localparam logic [15:0] ADDR_DIRECT_OUTPUT_SET = 16'h0822;
  localparam logic [15:0] ADDR_IO_STATUS_READOUT = 16'h082a;
  localparam logic [15:0] FUNCTION_SELECT_RESET = 16'h0000;
  localparam logic [15:0] DIRECT_OUTPUT_SET_RESET = 16'h0000;
  // function codes
  localparam logic [15:0] FN_IN_FREE = 16'h0001;
  localparam logic [15:0] FN_IN_FAULT_RESET = 16'h0002;
  localparam logic [15:0] FN_IN_ENABLE = 16'h0003;
  localparam logic [15:0] FN_IN_HALT = 16'h0004;
  localparam logic [15:0] FN_IN_JOG_POS = 16'h0009;
  localparam logic [15:0] FN_IN_JOG_NEG = 16'h000a;
  localparam logic [15:0] FN_IN_JOG_FAST = 16'h000b;
  localparam logic [15:0] FN_IN_REF_SWITCH = 16'h0014;
  localparam logic [15:0] FN_IN_POS_LIMIT = 16'h0015;
  localparam logic [15:0] FN_IN_NEG_LIMIT = 16'h0016;
  localparam logic [15:0] FN_OUT_FREE = 16'h0065;
  localparam logic [15:0] FN_OUT_NO_FAULT = 16'h0066;
  localparam logic [15:0] FN_OUT_ACTIVE = 16'h0067;
  // line indices that may carry the limit switch functions
  localparam int unsigned POS_LIMIT_LINE = 0;
  localparam int unsigned NEG_LIMIT_LINE = 1;
endpackage

/* test/io_function_select_asserts.sv */
// port-level checker for the configurable i/o function selector
module io_function_select_asserts
  import io_select_pkg::*;
#(
  parameter int unsigned LINES = NUM_LINES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // parameter port
  input wire logic par_sel,
  input wire logic par_we,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  input wire logic [15:0] par_rdata,
  input wire logic par_ack,
  input wire logic par_err,
  // lines and drive state
  input wire logic [LINES-1:0] line_in,
  input wire logic [LINES-1:0] line_oe,
  input wire logic local_mode,
  input wire logic fault_reset_req,
  input wire logic enable_req,
  input wire logic halt_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ack_after_req_a: assert property (par_sel |=> par_ack)
    else $error("access without ack");
  no_stray_ack_a: assert property (!par_sel |=> !par_ack)
    else $error("ack without access");
  err_with_ack_a: assert property (par_err |-> par_ack) else $error("lone err");
  status_write_refused_a: assert property (par_sel && par_we && par_addr == 16'h082a
    |=> par_err) else $error("status write taken");
  pos_limit_line_a: assert property (par_sel && par_we && par_addr == 16'h0726
    && par_wdata == 16'h0015 |=> par_err) else $error("limit code taken on line 3");
  neg_limit_line_a: assert property (par_sel && par_we && par_addr == 16'h0722
    && par_wdata == 16'h0016 |=> par_err) else $error("neg limit taken on line 1");
  status_readout_a: assert property (par_sel && !par_we && par_addr == 16'h082a
    && line_oe == '0 |=> par_rdata == 16'($past(line_in))) else $error("bad status");
  fault_reset_local_a: assert property (fault_reset_req |-> $past(local_mode))
    else $error("fault reset outside local mode");
  enable_local_a: assert property (enable_req |-> $past(local_mode))
    else $error("enable outside local mode");
  cover property (par_err);
  cover property (halt_req);
  cover property (line_oe[0] && par_ack);
endmodule // io_function_select_asserts

bind io_function_select io_function_select_asserts #(.LINES(LINES)) u_chk (.mclk(mclk),
  .rstn(rstn), .par_sel(par_sel), .par_we(par_we), .par_addr(par_addr),
  .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
  .line_in(line_in), .line_oe(line_oe), .local_mode(local_mode),
  .fault_reset_req(fault_reset_req), .enable_req(enable_req), .halt_req(halt_req));

/* test/io_line_loads.sv */
// external switches and loads on the configurable lines
module io_line_loads (
  // pin side
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe,
  // switch levels from the bench
  input wire logic [3:0] switch_level,
  output logic [3:0] line_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven line reads back its own level, so the switch must not fight it
  assign line_in = (line_oe & line_out) | (~line_oe & switch_level);
endmodule // io_line_loads

/* test/configurable_io_function_select_bench.sv */
// self-checking bench for the configurable i/o function selector
module configurable_io_function_select_bench import io_select_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rstn = 0, par_sel = 0, par_we = 0, par_ack, par_err;
  logic local_mode = 0, drive_fault = 0, op_enabled = 0;
  logic [15:0] par_addr = 16'h0000, par_wdata = 16'h0000, par_rdata;
  logic [3:0] line_in, line_out, line_oe, sw = 4'h0, dset = 4'h0;
  wire [8:0] fo;
  logic [15:0] sel [4] = '{default: 16'h0000};
  logic [16:0] rnd = 17'h123ca;
  int mismatches = 0, comparisons = 0;
  io_function_select #(.LINES(4)) DUT (.mclk(mclk), .rstn(rstn), .par_sel(par_sel),
    .par_we(par_we), .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_ack(par_ack), .par_err(par_err), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .local_mode(local_mode), .drive_fault(drive_fault),
    .op_enabled(op_enabled), .fault_reset_req(fo[0]), .enable_req(fo[1]), .halt_req(fo[2]),
    .jog_pos_req(fo[3]), .jog_neg_req(fo[4]), .jog_fast(fo[5]), .ref_switch(fo[6]),
    .positive_limit_switch(fo[7]), .negative_limit_switch(fo[8]));
  io_line_loads loads (.line_out(line_out), .line_oe(line_oe), .switch_level(sw),
    .line_in(line_in));
  initial begin
    forever #25 mclk = ~mclk;
  end
  task chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [16:0] lfsr(logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  function logic [3:0] m_oe();
    for (int i = 0; i < 4; i++) m_oe[i] = sel[i] inside {[FN_OUT_FREE:FN_OUT_ACTIVE]};
  endfunction
  function logic [3:0] m_out();
    for (int i = 0; i < 4; i++) m_out[i] = sel[i] == FN_OUT_FREE ? dset[i] :
      sel[i] == FN_OUT_NO_FAULT ? !drive_fault : sel[i] == FN_OUT_ACTIVE && op_enabled;
  endfunction
  function logic m_fn(logic [15:0] c);
    m_fn = 1'b0;
    for (int i = 0; i < 4; i++) m_fn |= sel[i] == c && sw[i];
  endfunction
  task acc(logic we, logic [15:0] a, logic [15:0] d);
    int i;
    logic [15:0] e;
    logic er;
    i = (a - 16'h0722) / 2;
    e = 16'h0000;
    er = 1'b0;
    if (a inside {16'h0722, 16'h0724, 16'h0726, 16'h0728}) begin
      e = sel[i];
      er = we && !(d inside {[FN_IN_FREE:FN_IN_HALT], [FN_IN_JOG_POS:FN_IN_JOG_FAST],
        FN_IN_REF_SWITCH, [FN_OUT_FREE:FN_OUT_ACTIVE]} || d == FN_IN_POS_LIMIT && i == 0
        || d == FN_IN_NEG_LIMIT && i == 1);
      if (we && !er) sel[i] = d;
    end else if (a == 16'h0822) begin
      e = 16'(dset);
      // only lines currently set to free output take the new bit
      for (int k = 0; k < 4; k++) if (we && sel[k] == FN_OUT_FREE) dset[k] = d[k];
    end else if (a == 16'h082a) begin
      e = 16'((m_oe() & m_out()) | (~m_oe() & sw));
      er = we;
    end else er = 1'b1;
    par_sel = 1;
    par_we = we;
    par_addr = a;
    par_wdata = d;
    @(negedge mclk);
    par_sel = 0;
    chk("ack", 16'(par_ack), 16'h0001);
    chk("err", 16'(par_err), 16'(er));
    chk("rdata", par_rdata, e);
    @(negedge mclk);
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    rstn = 1;
    @(negedge mclk);
    chk("oe", 16'(line_oe), 16'h0000);
    acc(0, 16'h0730, 16'h0000);
    acc(1, 16'h082a, 16'h0001);
    // codes 0..22 then 101..103 on every line, unlisted ones must be refused
    for (int i = 0; i < 4; i++) for (int c = 0; c < 26; c++) begin
      rnd = lfsr(rnd);
      acc(1, 16'h0722 + 16'(2 * i), 16'(c < 23 ? c : c + 78));
      sw = rnd[3:0];
      local_mode = rnd[4];
      drive_fault = rnd[5];
      op_enabled = rnd[6];
      acc(1, 16'h0822, 16'(rnd[10:7]));
      repeat (2) @(negedge mclk);
      chk("oe", 16'(line_oe), 16'(m_oe()));
      chk("out", 16'(line_out & line_oe), 16'(m_out()));
      chk("fn", 16'(fo), 16'({m_fn(FN_IN_NEG_LIMIT), m_fn(FN_IN_POS_LIMIT),
        m_fn(FN_IN_REF_SWITCH), m_fn(FN_IN_JOG_FAST), m_fn(FN_IN_JOG_NEG),
        m_fn(FN_IN_JOG_POS), m_fn(FN_IN_HALT), m_fn(FN_IN_ENABLE) && local_mode,
        m_fn(FN_IN_FAULT_RESET) && local_mode}));
      acc(0, 16'h082a, 16'h0000);
    end
    // mid-run reset: every line returns to an undriven input with no function
    rstn = 0;
    @(negedge mclk);
    chk("rst", 16'({fo, line_oe, par_ack, par_err}), 16'h0000);
    sel = '{default: 16'h0000};
    dset = 4'h0;
    rstn = 1;
    @(negedge mclk);
    acc(0, 16'h0728, 16'h0000);
    acc(0, 16'h0822, 16'h0000);
    acc(0, 16'h082a, 16'h0000);
    stop_test;
  end
endmodule // configurable_io_function_select_bench
